// ---- hw/llp_pkg.sv ----
// Purpose: constants and state type for the ladder logic primitives block
// Assumes: one scan cycle is one CLK period at 20 MHz
// Notes:   timing figures kept in their own units, cycle counts derived
// Behaviour
// (R1) at most three series contacts per rung
// (R2) three n/o in series give AND
// (R3) three n/c in series give NOR
// (R4) parallel n/o contacts give OR
// (R5) parallel n/c contacts give NAND
// (R6) parallel n/c on negated coil: five-input AND
// (R7) parallel n/o on negated coil: five-input NOR
// (R8) two-way output is exclusive OR
// (R9) start with stop closed latches, stop releases
// (R10) stop switch wired n/c, break stops
// (R11) reset coil after set coil wins
// (R12) toggle output flips on each rising edge
// (R13) rising-edge pulse lasts one scan cycle
// (R14) falling-edge pulse lasts one scan cycle
// (R15) contactor feedback energises star, starts changeover timer
// (R16) changeover 10 to 30 s, then star off
// (R17) delta on after 30/40/50/60 ms gap
// (R18) shift pulse loads value into stage one
// (R19) four stages, first through fourth in order
// (R20) clear forces all stages to zero
// (R21) user encodes reject as zero
// (R22) shift strobe one cycle per rising edge
// (R23) each stage takes old value of previous
// (R24) clear beats shift in same cycle
package llp_pkg;
   localparam int unsigned CLK_HZ          = 20000000;
   localparam int unsigned CHG_MIN_S       = 10;
   localparam int unsigned CHG_MAX_S       = 30;
   localparam int unsigned GAP_STEP_MS     = 10;
   localparam int unsigned GAP_BASE_MS     = 30;
   localparam int unsigned CYC_PER_S       = CLK_HZ;
   localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
   localparam int unsigned CHG_DEF_S       = 10;
   localparam int unsigned TMR_W           = 30;
   localparam int unsigned SYNC_W          = 20;
   localparam logic [3:0]  STAGE_RST       = 4'h0;

   typedef enum logic [1:0] {
      LLP_SD_IDLE  = 2'b00,
      LLP_SD_STAR  = 2'b01,
      LLP_SD_GAP   = 2'b10,
      LLP_SD_DELTA = 2'b11
   } llp_sd_t;

   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [SYNC_W-1:0] prev;
      logic              latch;
      logic              sr_out;
      logic              toggle;
      logic              rise;
      logic              fall;
      logic [7:0]        comb;
      llp_sd_t           sd;
      logic [TMR_W-1:0]  tmr;
      logic              star;
      logic              delta;
      logic              edge_memory_bit;
      logic              shift_strobe_bit;
      logic [3:0]        stage;
   } llp_state_t;
endpackage : llp_pkg

// ---- hw/llp_shift4.sv ----
// Purpose: four-stage shift register with edge-derived strobe and clear
// Assumes: inputs already synchronised to CLK
// Notes:   strobe comes one cycle after the input edge, as a scan-cycle marker would
`timescale 1ns/1ps
`default_nettype none
module llp_shift4
   import llp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       pulse,
   input  wire logic       value,
   input  wire logic       clear,
   output logic [3:0]      stage_q
);
   logic edge_memory_bit_q;
   logic shift_strobe_bit_q;
   logic [3:0] stage_d;

   always_comb begin
      stage_d = stage_q;
      if (shift_strobe_bit_q) begin
         stage_d = {stage_q[2:0], value}; // [R18] [R19] [R23]
      end
      if (clear) begin
         stage_d = STAGE_RST; // [R20] [R24]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         edge_memory_bit_q  <= 1'b0;
         shift_strobe_bit_q <= 1'b0;
         stage_q            <= STAGE_RST;
      end else begin
         edge_memory_bit_q  <= pulse;
         shift_strobe_bit_q <= pulse & ~edge_memory_bit_q; // [R22]
         stage_q            <= stage_d;
      end
   end
endmodule : llp_shift4
`default_nettype wire

// ---- hw/llp_top.sv ----
// Purpose: scan-cycle ladder primitives, latch, edge coils, star-delta, shift register
// Assumes: field inputs asynchronous; one CLK cycle is one scan cycle
// Notes:   every output is a flip-flop, so each coil shows one cycle after its contacts; shift stages move two cycles after the pulse
`timescale 1ns/1ps
`default_nettype none
module llp_top
   import llp_pkg::*;
#(
   parameter int unsigned CHG_CYC_UNIT = CYC_PER_S,
   parameter int unsigned GAP_CYC_UNIT = CYC_PER_MS
)
(
   input  wire logic       CLK,
   input  wire logic       RESETN,
   input  wire logic       INPUT_ONE,
   input  wire logic       INPUT_TWO,
   input  wire logic       INPUT_THREE,
   input  wire logic       INPUT_FOUR,
   input  wire logic       INPUT_FIVE,
   input  wire logic       START_SWITCH,
   input  wire logic       STOP_SWITCH,
   input  wire logic       TOGGLE_IN,
   input  wire logic       EDGE_IN,
   input  wire logic       MAINS_FEEDBACK,
   input  wire logic [4:0] CHANGEOVER_SEC,
   input  wire logic [1:0] GAP_SEL,
   input  wire logic       SHIFT_PULSE,
   input  wire logic       SHIFT_VALUE,
   input  wire logic       SHIFT_CLEAR,
   output logic            AND3_OUT,
   output logic            NOR3_OUT,
   output logic            OR3_OUT,
   output logic            NAND3_OUT,
   output logic            AND5_OUT,
   output logic            NOR5_OUT,
   output logic            XOR_OUT,
   output logic            LATCH_OUT,
   output logic            SR_LATCH_OUT,
   output logic            TOGGLE_OUT,
   output logic            RISE_PULSE,
   output logic            FALL_PULSE,
   output logic            STAR_OUT,
   output logic            DELTA_OUT,
   output logic            STAGE_ONE_BIT,
   output logic            STAGE_TWO_BIT,
   output logic            STAGE_THREE_BIT,
   output logic            STAGE_FOUR_BIT
);
   if (CHG_CYC_UNIT < 1 || GAP_CYC_UNIT < 1 ||
       64'(CHG_MAX_S) * 64'(CHG_CYC_UNIT) >= (64'd1 << TMR_W)) begin : g_bad_unit
      // refused at elaboration: the timer could not hold the longest changeover
      $error("llp_top: timer unit out of range");
   end

   llp_state_t        st_q;
   llp_state_t        st_d;
   logic [3:0]        stage_q;
   logic [SYNC_W-1:0] pin_w;
   logic              i1;
   logic              i2;
   logic              i3;
   logic              i4;
   logic              i5;
   logic              start_s;
   logic              stop_s;
   logic              tog_s;
   logic              edge_s;
   logic              mains_s;
   logic              shp_s;
   logic              shv_s;
   logic              shc_s;
   logic [4:0]        sec_s;
   logic [1:0]        gsel_s;

   // pins go to the first flop only; settings too, so a change mid-count is clean
   assign pin_w[0]     = INPUT_ONE;
   assign pin_w[1]     = INPUT_TWO;
   assign pin_w[2]     = INPUT_THREE;
   assign pin_w[3]     = INPUT_FOUR;
   assign pin_w[4]     = INPUT_FIVE;
   assign pin_w[5]     = START_SWITCH;
   assign pin_w[6]     = STOP_SWITCH;
   assign pin_w[7]     = TOGGLE_IN;
   assign pin_w[8]     = EDGE_IN;
   assign pin_w[9]     = MAINS_FEEDBACK;
   assign pin_w[10]    = SHIFT_PULSE;
   assign pin_w[11]    = SHIFT_VALUE;
   assign pin_w[12]    = SHIFT_CLEAR;
   assign pin_w[17:13] = CHANGEOVER_SEC;
   assign pin_w[19:18] = GAP_SEL;

   // logic reads the second flop only
   assign i1      = st_q.s2[0];
   assign i2      = st_q.s2[1];
   assign i3      = st_q.s2[2];
   assign i4      = st_q.s2[3];
   assign i5      = st_q.s2[4];
   assign start_s = st_q.s2[5];
   assign stop_s  = st_q.s2[6];
   assign tog_s   = st_q.s2[7];
   assign edge_s  = st_q.s2[8];
   assign mains_s = st_q.s2[9];
   assign shp_s   = st_q.s2[10];
   assign shv_s   = st_q.s2[11];
   assign shc_s   = st_q.s2[12];
   assign sec_s   = st_q.s2[17:13];
   assign gsel_s  = st_q.s2[19:18];

   function automatic logic series3(
      input logic a,
      input logic b,
      input logic c
   );
      // one rung: the coil sees its contacts in series
      series3 = a & b & c;
   endfunction : series3

   function automatic logic parallel5(
      input logic [4:0] v
   );
      // parallel rungs on one coil
      parallel5 = |v;
   endfunction : parallel5

   function automatic logic [TMR_W-1:0] chg_limit(
      input logic [4:0] sec
   );
      logic [4:0] s;
      s = sec;
      // out-of-range settings clamp rather than run a zero or runaway timer
      if (s < 5'(CHG_MIN_S)) begin
         s = 5'(CHG_MIN_S);
      end
      if (s > 5'(CHG_MAX_S)) begin
         s = 5'(CHG_MAX_S);
      end
      chg_limit = TMR_W'(64'(s) * 64'(CHG_CYC_UNIT)); // [R16]
   endfunction : chg_limit

   function automatic logic [TMR_W-1:0] gap_limit(
      input logic [1:0] sel
   );
      logic [7:0] ms;
      ms = 8'(GAP_BASE_MS) + 8'(GAP_STEP_MS) * 8'(sel);
      gap_limit = TMR_W'(64'(ms) * 64'(GAP_CYC_UNIT)); // [R17]
   endfunction : gap_limit

   // edge decode shared by the pulse coils and the toggle relay
   function automatic logic rising(
      input logic cur,
      input logic old
   );
      rising = cur & ~old;
   endfunction : rising

   function automatic logic falling(
      input logic cur,
      input logic old
   );
      falling = ~cur & old;
   endfunction : falling

   always_comb begin
      logic fb;
      logic rung_and3;
      logic rung_nor3;
      logic rung_or3;
      logic rung_nand3;
      logic rung_and5;
      logic rung_nor5;
      logic rung_xa;
      logic rung_xb;
      fb = 1'b0;
      rung_and3 = 1'b0;
      rung_nor3 = 1'b0;
      rung_or3 = 1'b0;
      rung_nand3 = 1'b0;
      rung_and5 = 1'b0;
      rung_nor5 = 1'b0;
      rung_xa = 1'b0;
      rung_xb = 1'b0;
      st_d = st_q;

      // synchroniser: s1 takes the pins, s2 takes s1, prev keeps s2 for edges
      st_d.s1 = pin_w;
      st_d.s2 = st_q.s1;
      st_d.prev = st_q.s2;

      // each rung holds at most three series contacts; wide terms use negated coils
      rung_and3 = series3(i1, i2, i3);                           // [R1] [R2]
      rung_nor3 = series3(~i1, ~i2, ~i3);                        // [R3]
      rung_or3 = parallel5({2'b00, i3, i2, i1});                 // [R4]
      rung_nand3 = parallel5({2'b00, ~i3, ~i2, ~i1});            // [R5]
      rung_and5 = ~parallel5({~i5, ~i4, ~i3, ~i2, ~i1});         // [R6]
      rung_nor5 = ~parallel5({i5, i4, i3, i2, i1});              // [R7]
      rung_xa = series3(i1, ~i2, 1'b1);
      rung_xb = series3(~i1, i2, 1'b1);
      st_d.comb[0] = rung_and3;
      st_d.comb[1] = rung_nor3;
      st_d.comb[2] = rung_or3;
      st_d.comb[3] = rung_nand3;
      st_d.comb[4] = rung_and5;
      st_d.comb[5] = rung_nor5;
      st_d.comb[6] = parallel5({3'b000, rung_xb, rung_xa});      // [R8]
      st_d.comb[7] = 1'b0;

      // stop reads 1 when idle, so a broken wire also drops the latch
      st_d.latch = (start_s | st_q.latch) & stop_s; // [R9] [R10]

      // set first, reset last: reset wins with start still held
      if (start_s) begin
         st_d.sr_out = 1'b1;
      end
      if (!stop_s) begin
         st_d.sr_out = 1'b0; // [R11]
      end

      st_d.rise = rising(edge_s, st_q.prev[8]);  // [R13]
      st_d.fall = falling(edge_s, st_q.prev[8]); // [R14]
      if (rising(tog_s, st_q.prev[7])) begin
         st_d.toggle = ~st_q.toggle; // [R12]
      end

      // star-delta: the timer counts scans inside the current phase only
      st_d.tmr = st_q.tmr + TMR_W'(1);
      case (st_q.sd)
         LLP_SD_IDLE: begin
            st_d.tmr = '0;
            if (mains_s) begin
               st_d.sd = LLP_SD_STAR; // [R15]
               st_d.star = 1'b1;
               st_d.delta = 1'b0;
            end
         end
         LLP_SD_STAR: begin
            if (st_q.tmr + TMR_W'(1) >= chg_limit(sec_s)) begin
               st_d.sd = LLP_SD_GAP; // [R16]
               st_d.star = 1'b0;
               st_d.tmr = '0;
            end
         end
         LLP_SD_GAP: begin
            if (st_q.tmr + TMR_W'(1) >= gap_limit(gsel_s)) begin
               st_d.sd = LLP_SD_DELTA; // [R17]
               st_d.delta = 1'b1;
               st_d.tmr = '0;
            end
         end
         LLP_SD_DELTA: begin
            st_d.tmr = '0;
            st_d.star = 1'b0;
         end
         default: begin
            fb = 1'b1;
         end
      endcase
      // dropping the mains contactor aborts the sequence with both contactors off
      if (!mains_s || fb) begin
         st_d.sd = LLP_SD_IDLE;
         st_d.star = 1'b0;
         st_d.delta = 1'b0;
         st_d.tmr = '0;
      end

      // shift register state lives in the child; only the stages are mirrored here, the strobe and edge bits read zero
      st_d.edge_memory_bit = 1'b0;
      st_d.shift_strobe_bit = 1'b0;
      st_d.stage = stage_q;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   llp_shift4 u_shift (
      .clk     (CLK),
      .rst_n   (RESETN),
      .pulse   (shp_s),
      .value   (shv_s),
      .clear   (shc_s),
      .stage_q (stage_q)
   );

   assign AND3_OUT        = st_q.comb[0];
   assign NOR3_OUT        = st_q.comb[1];
   assign OR3_OUT         = st_q.comb[2];
   assign NAND3_OUT       = st_q.comb[3];
   assign AND5_OUT        = st_q.comb[4];
   assign NOR5_OUT        = st_q.comb[5];
   assign XOR_OUT         = st_q.comb[6];
   assign LATCH_OUT       = st_q.latch;
   assign SR_LATCH_OUT    = st_q.sr_out;
   assign TOGGLE_OUT      = st_q.toggle;
   assign RISE_PULSE      = st_q.rise;
   assign FALL_PULSE      = st_q.fall;
   assign STAR_OUT        = st_q.star;
   assign DELTA_OUT       = st_q.delta;
   assign STAGE_ONE_BIT   = stage_q[0];
   assign STAGE_TWO_BIT   = stage_q[1];
   assign STAGE_THREE_BIT = stage_q[2];
   assign STAGE_FOUR_BIT  = stage_q[3];
endmodule : llp_top
`default_nettype wire

// ---- tb/llp_chk_sva.sv ----
// Purpose: port checks for the ladder primitives
// Assumes: outputs lag their pins by three edges
// Notes:   armed once the sync chain refills after reset
`timescale 1ns/1ps
`default_nettype none
module llp_chk #(
   parameter int unsigned CHG_CYC_UNIT = 1,
   parameter int unsigned GAP_CYC_UNIT = 1
)(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic INPUT_ONE,
   input wire logic INPUT_TWO,
   input wire logic INPUT_THREE,
   input wire logic INPUT_FOUR,
   input wire logic INPUT_FIVE,
   input wire logic STOP_SWITCH,
   input wire logic EDGE_IN,
   input wire logic AND3_OUT,
   input wire logic NAND3_OUT,
   input wire logic AND5_OUT,
   input wire logic NOR5_OUT,
   input wire logic XOR_OUT,
   input wire logic SR_LATCH_OUT,
   input wire logic RISE_PULSE,
   input wire logic FALL_PULSE,
   input wire logic STAR_OUT,
   input wire logic DELTA_OUT
);
   logic [2:0] up_q;
   logic       rdy, a3, a5, o5, x2;
   always_ff @(posedge CLK or negedge RESETN)
      if (!RESETN) up_q <= 3'h0;
      else if (up_q != 3'h7) up_q <= up_q + 3'h1;
   assign rdy = (up_q > 3'h4);
   assign a3 = INPUT_ONE & INPUT_TWO & INPUT_THREE;
   assign a5 = a3 & INPUT_FOUR & INPUT_FIVE;
   assign o5 = a3 | INPUT_ONE | INPUT_TWO | INPUT_THREE | INPUT_FOUR | INPUT_FIVE;
   assign x2 = INPUT_ONE ^ INPUT_TWO;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence s_star_end;
      $fell(STAR_OUT);
   endsequence
   a_and3_gate: assert property (rdy |-> AND3_OUT == $past(a3, 3)) else $error("and3 bad");
   a_nand3_gate: assert property (rdy |-> NAND3_OUT != $past(a3, 3)) else $error("nand3 bad");
   a_and5_gate: assert property (rdy |-> AND5_OUT == $past(a5, 3)) else $error("and5 bad");
   a_nor5_gate: assert property (rdy |-> NOR5_OUT != $past(o5, 3)) else $error("nor5 bad");
   a_xor_gate: assert property (rdy |-> XOR_OUT == $past(x2, 3)) else $error("xor bad");
   a_rise_one: assert property (rdy |-> RISE_PULSE == ($past(EDGE_IN, 3) && !$past(EDGE_IN, 4)))
      else $error("rise pulse bad");
   a_fall_one: assert property (rdy |-> FALL_PULSE == (!$past(EDGE_IN, 3) && $past(EDGE_IN, 4)))
      else $error("fall pulse bad");
   a_stop_wins: assert property (rdy && !$past(STOP_SWITCH, 3) |-> !SR_LATCH_OUT)
      else $error("stop not obeyed");
   a_delta_gap: assert property (s_star_end |-> !DELTA_OUT [*8]) else $error("no gap");
endmodule : llp_chk
`default_nettype wire

// ---- tb/llp_field.sv ----
// Purpose: field side model: n/c stop button and mains contactor
// Assumes: contactor pulls in two clk cycles after its command
// Notes:   slow pull-in keeps star timing honest
`timescale 1ns/1ps
`default_nettype none
module llp_field (
   input  wire logic clk,
   input  wire logic stop_press,
   input  wire logic wire_cut,
   input  wire logic mains_cmd,
   output logic      stop_sw,
   output logic      mains_fb
);
   logic [1:0] pick_q = 2'h0;
   // idle reads 1, a press or a broken wire reads 0
   assign stop_sw = !(stop_press || wire_cut);
   always_ff @(posedge clk) pick_q <= {pick_q[0], mains_cmd};
   assign mains_fb = pick_q[1];
endmodule : llp_field
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: self-checking bench for llp_top
// Assumes: short timer units, 10 cycles per second and 2 per ms
// Notes:   checks at negedge so registered outputs have settled
`timescale 1ns/1ps
`default_nettype none
module tb;
   import llp_pkg::*;
   localparam logic [4:0] SECS [4] = '{5'h05, 5'h0A, 5'h1E, 5'h1F};
   localparam logic [3:0] EXP [5] = '{4'h1, 4'h2, 4'h4, 4'h9, 4'h2};
   logic       clk = 0, rst_n = 0, start = 0, stp = 0, cut = 0, mcmd = 0;
   logic       tgl = 0, edg = 0, sp = 0, sv = 0, sc = 0;
   logic [4:0] ins = 5'h00, sec = 5'h0A;
   logic [1:0] gsel = 2'h0;
   int         num_errors = 0, num_checks = 0;
   wire logic  stop_sw, mains_fb, and3, nor3, or3, nand3, and5, nor5, xo;
   wire logic  lat, srl, tog, rp, fp, star, dlt;
   wire logic [3:0] stg;
   always #25 clk = ~clk;
   llp_field u_field (.clk(clk), .stop_press(stp), .wire_cut(cut), .mains_cmd(mcmd),
      .stop_sw(stop_sw), .mains_fb(mains_fb));
   llp_top #(.CHG_CYC_UNIT(10), .GAP_CYC_UNIT(2)) dut (.CLK(clk), .RESETN(rst_n),
      .INPUT_ONE(ins[0]), .INPUT_TWO(ins[1]), .INPUT_THREE(ins[2]), .INPUT_FOUR(ins[3]),
      .INPUT_FIVE(ins[4]), .START_SWITCH(start), .STOP_SWITCH(stop_sw), .TOGGLE_IN(tgl),
      .EDGE_IN(edg), .MAINS_FEEDBACK(mains_fb), .CHANGEOVER_SEC(sec), .GAP_SEL(gsel),
      .SHIFT_PULSE(sp), .SHIFT_VALUE(sv), .SHIFT_CLEAR(sc), .AND3_OUT(and3),
      .NOR3_OUT(nor3), .OR3_OUT(or3), .NAND3_OUT(nand3), .AND5_OUT(and5), .NOR5_OUT(nor5),
      .XOR_OUT(xo), .LATCH_OUT(lat), .SR_LATCH_OUT(srl), .TOGGLE_OUT(tog), .RISE_PULSE(rp),
      .FALL_PULSE(fp), .STAR_OUT(star), .DELTA_OUT(dlt), .STAGE_ONE_BIT(stg[0]),
      .STAGE_TWO_BIT(stg[1]), .STAGE_THREE_BIT(stg[2]), .STAGE_FOUR_BIT(stg[3]));
   task w(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : w
   task chk(input logic [3:0] e, input logic [3:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask : chk
   task give_verdict;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   task t_gates;
      for (int v = 0; v < 32; v++) begin
         @(posedge clk) ins <= v[4:0];
         w(4);
         chk(&v[2:0], and3);
         chk(~|v[2:0], nor3);
         chk(|v[2:0], or3);
         chk(~&v[2:0], nand3);
         chk(&v[4:0], and5);
         chk(~|v[4:0], nor5);
         chk(v[0] ^ v[1], xo);
      end
   endtask : t_gates
   task t_latch;
      @(posedge clk) start <= 1;
      w(4);
      chk(2'h3, {lat, srl});
      @(posedge clk) start <= 0;
      w(4);
      chk(2'h3, {lat, srl});
      @(posedge clk) begin start <= 1; stp <= 1; end
      w(4);
      chk(2'h0, {lat, srl});
      @(posedge clk) stp <= 0;
      w(4);
      chk(2'h3, {lat, srl});
      @(posedge clk) begin start <= 0; cut <= 1; end
      w(4);
      chk(2'h0, {lat, srl});
      @(posedge clk) cut <= 0;
   endtask : t_latch
   task t_edges;
      logic t;
      t = 0;
      repeat (2) begin
         @(posedge clk) begin edg <= 1; tgl <= 1; end
         w(3);
         chk(1, rp);
         t = ~t;
         w(1);
         chk({1'b0, t}, {rp, tog});
         @(posedge clk) begin edg <= 0; tgl <= 0; end
         w(3);
         chk(1, fp);
         w(1);
         chk({1'b0, t}, {fp, tog});
      end
   endtask : t_edges
   task t_star;
      int n, e;
      for (int g = 0; g < 4; g++) begin
         @(posedge clk) begin sec <= SECS[g]; gsel <= g[1:0]; mcmd <= 1; end
         w(6);
         chk(2'h2, {star, dlt});
         n = 0;
         while (star === 1'b1 && n < 800) begin w(1); n++; end
         e = (g < 2) ? 100 : 300;
         chk(1, n > e - 9 && n < e + 2);
         n = 0;
         while (dlt !== 1'b1 && n < 400) begin w(1); n++; end
         e = (30 + 10 * g) * 2;
         chk(1, n > e - 4 && n < e + 4);
         @(posedge clk) mcmd <= 0;
         w(6);
         chk(2'h0, {star, dlt});
      end
   endtask : t_star
   task t_shift;
      for (int k = 0; k < 5; k++) begin
         // pulse held for several scans must shift once; value 0 marks a reject
         @(posedge clk) begin sp <= 1; sv <= EXP[k][0]; end
         w(3);
         @(posedge clk) sp <= 0;
         w(5);
         chk(EXP[k], stg);
      end
      @(posedge clk) sc <= 1;
      w(4);
      chk(0, stg);
      @(posedge clk) begin sp <= 1; sv <= 1; end
      w(6);
      chk(0, stg);
      @(posedge clk) begin sc <= 0; sp <= 0; end
      w(6);
      chk(0, stg);
   endtask : t_shift
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1;
      w(2);
      t_gates;
      t_latch;
      t_edges;
      t_star;
      t_shift;
      give_verdict;
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      give_verdict;
   end
endmodule : tb
bind llp_top llp_chk #(.CHG_CYC_UNIT(CHG_CYC_UNIT), .GAP_CYC_UNIT(GAP_CYC_UNIT)) u_chk (.*);
`default_nettype wire
